/* File: bench/tb.sv */
// Purpose : self-checking bench for the zero-cross detector control block
// Assumes : axi4-lite master tasks, one 250 MHz clock
// Notes   : clock enable and write strobes are held high, every other input is exercised
module tb
    import zcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        aclk, aresetn, fuse, sink_cmd, sink_sense, sleep;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd_q;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp_q;
    logic        active, det_out, irq;
    int          fail_count, tests_run;

    zcd_src_model src (.sink_cmd(sink_cmd), .sink_sense(sink_sense));

    zcd_top dut (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .detector_disable_fuse(fuse),
        .sink_sense(sink_sense), .sleep(sleep),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .detector_active(active),
        .detector_logic_output(det_out), .irq(irq)
    );

    // ==========================================================
    // clock and shared tasks
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask : idle

    // address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        int  n;
        bit  aw_ok, w_ok;
        n = 0;
        aw_ok = 0;
        w_ok = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (!aw_ok && awready) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok && bvalid) && n < 100);
        resp_q = bresp;
        bready <= 1'b0;
        if (!(aw_ok && w_ok && bvalid)) begin
            fail_count++;
            stop_test();
        end
        @(posedge aclk);
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a);
        int n;
        bit ar_ok;
        n = 0;
        ar_ok = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (!ar_ok && arready) begin
                ar_ok = 1;
                arvalid <= 1'b0;
            end
        end while (!(ar_ok && rvalid) && n < 100);
        rd_q = rdata;
        resp_q = rresp;
        rready <= 1'b0;
        if (!(ar_ok && rvalid)) begin
            fail_count++;
            stop_test();
        end
        @(posedge aclk);
    endtask : axi_rd

    task automatic do_reset(input logic f);
        fuse <= f;
        aresetn <= 1'b0;
        idle(8);
        aresetn <= 1'b1;
        idle(4);
    endtask : do_reset

    // ==========================================================
    // main sequence
    initial begin
        fail_count = 0;
        tests_run = 0;
        {aresetn, fuse, sink_cmd, sleep} = 4'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h0;
        do_reset(1'b0);
        check({31'h0, active}, 32'h1);
        axi_rd(ZCD_OFF_CTRL);
        check(rd_q, 32'h80);
        check({30'h0, resp_q}, {30'h0, ZCD_RESP_OKAY});
        // reserved positions and upper bits ignore the write
        axi_wr(ZCD_OFF_CTRL, 32'hFFFF_FFFF);
        check({30'h0, resp_q}, {30'h0, ZCD_RESP_OKAY});
        idle(8);
        axi_rd(ZCD_OFF_CTRL);
        check(rd_q, 32'hB3);
        // unaligned offsets are unmapped and answer with an error
        axi_wr(4'h2, 32'h0);
        check({30'h0, resp_q}, {30'h0, ZCD_RESP_SLVERR});
        axi_rd(4'h6);
        check({30'h0, resp_q}, {30'h0, ZCD_RESP_SLVERR});
        // level bit and output across invert and pin state
        for (int k = 0; k < 4; k++) begin
            axi_wr(ZCD_OFF_CTRL, 32'h80 | (32'(k[1]) << 4));
            sink_cmd <= k[0];
            idle(8);
            check({31'h0, det_out}, 32'(k[0] ^ k[1]));
            axi_rd(ZCD_OFF_CTRL);
            check(rd_q, 32'h80 | (32'(k[1]) << 4) | (32'(k[0] ^ k[1]) << 5));
        end
        // edge enables in every combination, sleep asserted throughout
        sleep <= 1'b1;
        axi_wr(ZCD_OFF_IEN, 32'h1);
        for (int k = 0; k < 4; k++) begin
            axi_wr(ZCD_OFF_CTRL, 32'h80 | 32'(k[1:0]));
            sink_cmd <= 1'b0;
            idle(8);
            axi_wr(ZCD_OFF_CLR, 32'h1);
            axi_rd(ZCD_OFF_STAT);
            check(rd_q, 32'h0);
            sink_cmd <= 1'b1;
            idle(8);
            check({31'h0, irq}, 32'(k[1]));
            axi_wr(ZCD_OFF_STAT, 32'h0);
            axi_rd(ZCD_OFF_STAT);
            check(rd_q, 32'(k[1]));
            axi_wr(ZCD_OFF_CLR, 32'h1);
            sink_cmd <= 1'b0;
            idle(8);
            axi_rd(ZCD_OFF_STAT);
            check(rd_q, 32'(k[0]));
            check({31'h0, irq}, 32'(k[0]));
        end
        // masking hides the flag from the interrupt, flag stays set
        axi_wr(ZCD_OFF_IEN, 32'h0);
        check({31'h0, irq}, 32'h0);
        axi_rd(ZCD_OFF_STAT);
        check(rd_q, 32'h1);
        axi_rd(ZCD_OFF_CLR);
        check(rd_q, 32'h0);
        axi_wr(ZCD_OFF_IEN, 32'h1);
        idle(2);
        check({31'h0, irq}, 32'h1);
        sleep <= 1'b0;
        // fuse set: detector stays off until software enables it
        do_reset(1'b1);
        check({31'h0, active}, 32'h0);
        axi_rd(ZCD_OFF_CTRL);
        check(rd_q, 32'h0);
        axi_wr(ZCD_OFF_CTRL, 32'h80);
        idle(2);
        check({31'h0, active}, 32'h1);
        stop_test();
    end
endmodule : tb

/* File: bench/zcd_src_model.sv */
// Purpose : behavioural ac source seen through the series resistor
// Assumes : bench commands whether the pin sinks or sources current
// Notes   : output moves off the clock grid, as a real comparator would
// ==========================================================
// partner model
module zcd_src_model
(
    input  wire logic sink_cmd,
    output logic      sink_sense
);
    timeunit 1ns;
    timeprecision 100ps;

    initial sink_sense = 1'b0;

    // fixed skew keeps the change unrelated to the sampling edge
    always @(sink_cmd) begin
        sink_sense <= #1.3 sink_cmd;
    end
endmodule : zcd_src_model

/* File: rtl/zcd_edge.sv */
// Purpose : polarity adjust and edge detection of the detector level
// Assumes : level input already synchronised to aclk
// Notes   : compares against the value one clock earlier
module zcd_edge
    import zcd_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    input  wire logic active,
    input  wire logic invert,
    input  wire logic raw_level,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    typedef struct packed {
        logic prev;
        logic armed;
    } zcd_edge_st_t;

    zcd_edge_st_t st_q;
    zcd_edge_st_t st_d;
    logic         adj;

    // ==========================================================
    // inversion, then compare with last cycle
    assign adj   = active & (raw_level ^ invert);
    assign level = adj;

    always_comb begin
        st_d       = st_q;
        st_d.prev  = adj;
        st_d.armed = 1'b1;
    end

    // armed hides the bogus edge of the first cycle after reset
    assign rise = st_q.armed & adj & ~st_q.prev;
    assign fall = st_q.armed & ~adj & st_q.prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

endmodule : zcd_edge

/* File: rtl/zcd_pkg.sv */
// Purpose : shared constants and types of the zero-cross detector control block
// Assumes : 32-bit axi4-lite register bus, one system clock
// Notes   : register offsets are byte addresses of aligned words
package zcd_pkg;

    // ==========================================================
    // register map
    localparam logic [3:0] ZCD_OFF_CTRL   = 4'h0; // control and level
    localparam logic [3:0] ZCD_OFF_STAT   = 4'h4; // sticky event status, read only
    localparam logic [3:0] ZCD_OFF_CLR    = 4'h8; // write one to clear status
    localparam logic [3:0] ZCD_OFF_IEN    = 4'hC; // interrupt enable

    // ==========================================================
    // control register fields
    localparam int ZCD_BIT_FALL   = 0;
    localparam int ZCD_BIT_RISE   = 1;
    localparam int ZCD_BIT_INV    = 4;
    localparam int ZCD_BIT_LEVEL  = 5;
    localparam int ZCD_BIT_EN     = 7;
    localparam logic [7:0] ZCD_CTRL_WMASK = 8'h93; // writable bits; level bit reads the detector, others read zero

    // strap taken when this many cycles have passed since reset release,
    // the time the fuse level needs to walk through both synchroniser stages
    localparam logic [1:0] ZCD_STRAP_AT   = 2'h2;

    // status field: the shared zero-cross flag
    localparam int ZCD_BIT_FLAG   = 0;

    // ==========================================================
    // axi response codes
    localparam logic [1:0] ZCD_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ZCD_RESP_SLVERR = 2'h2;

    // control fields travel together
    typedef struct packed {
        logic detector_enable;
        logic output_invert;
        logic rising_edge_flag_enable;
        logic falling_edge_flag_enable;
    } zcd_ctrl_t;

endpackage : zcd_pkg

/* File: rtl/zcd_sync.sv */
// Purpose : two flip-flop synchroniser for the analog comparator level
// Assumes : input is asynchronous to aclk
// Notes   : first stage is read only by the second stage
module zcd_sync
    import zcd_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    input  wire logic din,
    output logic      dout
);

    typedef struct packed {
        logic meta;
        logic sync;
    } zcd_sync_st_t;

    zcd_sync_st_t st_q;
    zcd_sync_st_t st_d;

    // ==========================================================
    // two stage chain
    always_comb begin
        st_d      = st_q;
        st_d.meta = din;
        st_d.sync = st_q.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.sync;

endmodule : zcd_sync

/* File: rtl/zcd_top.sv */
// Purpose : zero-cross detector control with axi4-lite registers
// Assumes : sink_sense high while the pin sinks current, asynchronous
// Notes   : sleep has no clock gating here, so logic runs on in sleep
// Notes on behaviour
// - the invert bit flips the detector logic output, clear passes it straight.
// - the level bit reads one while sinking with invert clear, meanings swapped when set.
// - the rising enable sets the shared flag on each low-to-high output change.
// - the falling enable sets the shared flag on each high-to-low output change.
// - bits six, three and two of control read zero and ignore writes.
// - with the disable fuse set the detector stays off until software enables it.
// - with the fuse clear the detector comes up active and the enable resets set.
// - detection and flag setting keep running in sleep.
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
module zcd_top
    import zcd_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        detector_disable_fuse,
    input  wire logic        sink_sense,
    input  wire logic        sleep,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             detector_active,
    output logic             detector_logic_output,
    output logic             irq
);

    // ==========================================================
    // state
    typedef struct packed {
        zcd_ctrl_t   ctrl;
        logic        strap_done;
        logic [1:0]  strap_cnt;
        logic        zero_cross_flag;
        logic        flag_ien;
        logic        aw_got;
        logic [3:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic        w_strb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        level;
        logic        irq;
    } zcd_state_t;

    zcd_state_t st_q;
    zcd_state_t st_d;

    logic       fuse_s;
    logic       sense_s;
    logic       level_w;
    logic       rise_w;
    logic       fall_w;
    logic       do_write;
    logic       do_read;
    logic       set_flag;
    logic [7:0] ctrl_rd;

    // ==========================================================
    // pin synchronisers
    zcd_sync u_sync_fuse (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .din     (detector_disable_fuse),
        .dout    (fuse_s)
    );

    zcd_sync u_sync_sense (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .din     (sink_sense),
        .dout    (sense_s)
    );

    // ==========================================================
    // detector edges; sleep is deliberately not an input here
    zcd_edge u_edge (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .active    (st_q.ctrl.detector_enable),
        .invert    (st_q.ctrl.output_invert),
        .raw_level (sense_s),
        .level     (level_w),
        .rise      (rise_w),
        .fall      (fall_w)
    );

    // ==========================================================
    // flag causes
    assign set_flag = (rise_w & st_q.ctrl.rising_edge_flag_enable)
                    | (fall_w & st_q.ctrl.falling_edge_flag_enable);

    // control read image, unused bits forced to zero
    always_comb begin
        ctrl_rd                = 8'h00;
        ctrl_rd[ZCD_BIT_EN]    = st_q.ctrl.detector_enable;
        ctrl_rd[ZCD_BIT_LEVEL] = st_q.level;
        ctrl_rd[ZCD_BIT_INV]   = st_q.ctrl.output_invert;
        ctrl_rd[ZCD_BIT_RISE]  = st_q.ctrl.rising_edge_flag_enable;
        ctrl_rd[ZCD_BIT_FALL]  = st_q.ctrl.falling_edge_flag_enable;
    end

    assign do_write = st_q.aw_got & st_q.w_got & ~st_q.bvalid;
    assign do_read  = s_axi_arvalid & ~st_q.rvalid;

    // ==========================================================
    // next state
    always_comb begin
        st_d       = st_q;
        st_d.level = level_w;

        // fuse strap caught once; the synchroniser is cleared by reset, so
        // reading it earlier would always see the fuse as clear
        if (!st_q.strap_done) begin
            st_d.strap_cnt = st_q.strap_cnt + 2'h1;
            if (st_q.strap_cnt == ZCD_STRAP_AT) begin
                st_d.strap_done           = 1'b1;
                st_d.ctrl.detector_enable = ~fuse_s;
            end
        end

        // write address and data, either order
        if (s_axi_awvalid && !st_q.aw_got) begin
            st_d.aw_got  = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_got) begin
            st_d.w_got   = 1'b1;
            st_d.w_data  = s_axi_wdata;
            st_d.w_strb0 = s_axi_wstrb[0];
        end

        // hardware set comes after software clear so set wins
        if (do_write) begin
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = ZCD_RESP_OKAY;
            case (st_q.aw_addr)
                ZCD_OFF_CTRL: begin
                    if (st_q.w_strb0) begin
                        st_d.ctrl.detector_enable          = st_q.w_data[ZCD_BIT_EN];
                        st_d.ctrl.output_invert            = st_q.w_data[ZCD_BIT_INV];
                        st_d.ctrl.rising_edge_flag_enable  = st_q.w_data[ZCD_BIT_RISE];
                        st_d.ctrl.falling_edge_flag_enable = st_q.w_data[ZCD_BIT_FALL];
                    end
                end
                ZCD_OFF_STAT: begin
                    st_d.bresp = ZCD_RESP_OKAY;
                end
                ZCD_OFF_CLR: begin
                    if (st_q.w_strb0 && st_q.w_data[ZCD_BIT_FLAG]) begin
                        st_d.zero_cross_flag = 1'b0;
                    end
                end
                ZCD_OFF_IEN: begin
                    if (st_q.w_strb0) begin
                        st_d.flag_ien = st_q.w_data[ZCD_BIT_FLAG];
                    end
                end
                default: begin
                    st_d.bresp = ZCD_RESP_SLVERR;
                end
            endcase
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end

        if (set_flag) begin
            st_d.zero_cross_flag = 1'b1;
        end

        // reads answered the cycle after address is taken
        if (do_read) begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = ZCD_RESP_OKAY;
            st_d.rdata  = 32'h0000_0000;
            case (s_axi_araddr)
                ZCD_OFF_CTRL: st_d.rdata[7:0]          = ctrl_rd;
                ZCD_OFF_STAT: st_d.rdata[ZCD_BIT_FLAG] = st_q.zero_cross_flag;
                ZCD_OFF_CLR:  st_d.rdata               = 32'h0000_0000;
                ZCD_OFF_IEN:  st_d.rdata[ZCD_BIT_FLAG] = st_q.flag_ien;
                default:      st_d.rresp               = ZCD_RESP_SLVERR;
            endcase
        end else if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end

        st_d.irq = st_d.zero_cross_flag & st_d.flag_ien;
    end

    // ==========================================================
    // registers; ce low freezes everything
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // outputs straight from flops
    assign s_axi_awready         = ~st_q.aw_got;
    assign s_axi_wready          = ~st_q.w_got;
    assign s_axi_bvalid          = st_q.bvalid;
    assign s_axi_bresp           = st_q.bresp;
    assign s_axi_arready         = ~st_q.rvalid;
    assign s_axi_rvalid          = st_q.rvalid;
    assign s_axi_rdata           = st_q.rdata;
    assign s_axi_rresp           = st_q.rresp;
    assign detector_active       = st_q.ctrl.detector_enable;
    assign detector_logic_output = st_q.level;
    assign irq                   = st_q.irq;

    // ==========================================================
    // checks
    flag_holds_a : assert property (@(posedge aclk) disable iff (!aresetn)
        ce && st_q.zero_cross_flag && !do_write |=> st_q.zero_cross_flag)
        else $error("flag dropped without a clear");

    rise_sets_a : assert property (@(posedge aclk) disable iff (!aresetn)
        ce && rise_w && st_q.ctrl.rising_edge_flag_enable |=> st_q.zero_cross_flag)
        else $error("rising edge did not set flag");

    fall_sets_a : assert property (@(posedge aclk) disable iff (!aresetn)
        ce && fall_w && st_q.ctrl.falling_edge_flag_enable |=> st_q.zero_cross_flag)
        else $error("falling edge did not set flag");

    no_cause_a : assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !st_q.zero_cross_flag && !set_flag |=> !st_q.zero_cross_flag)
        else $error("flag set without enabled edge");

    level_inv_a : assert property (@(posedge aclk) disable iff (!aresetn)
        ce && st_q.ctrl.detector_enable
        |-> level_w == (sense_s ^ st_q.ctrl.output_invert))
        else $error("level polarity wrong");

    level_rd_a : assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> st_q.level == $past(level_w))
        else $error("level bit stale");

    unused_zero_a : assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_rd & 8'h4C) == 8'h00)
        else $error("unused control bits not zero");

    fuse_strap_a : assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !st_q.strap_done && st_q.strap_cnt == ZCD_STRAP_AT && !do_write
        |=> st_q.ctrl.detector_enable == !$past(fuse_s))
        else $error("enable reset value ignores fuse");

    sleep_run_a : assert property (@(posedge aclk) disable iff (!aresetn)
        ce && sleep && set_flag |=> st_q.zero_cross_flag)
        else $error("flag halted in sleep");

    irq_level_a : assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> irq == (st_q.zero_cross_flag & st_q.flag_ien))
        else $error("irq not matching flag and enable");

endmodule : zcd_top
